/* File: rtl/smc_pkg.sv */
/*
 * Shared constants and types of the serializer mode and power control block.
 * Assumes a 100 MHz core clock; all cycle counts below derive from that rate.
 */
package smc_pkg;

   // clock
   localparam int CLK_PERIOD_NS = 10;

   // register map, 8-bit register port
   localparam logic [7:0] REV_CFG_ADDR = 8'h1A;
   localparam logic [7:0] CTRL_CFG_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h05;
   localparam logic [7:0] REV_CFG_RESET = 8'h00;
   localparam logic [7:0] CTRL_CFG_RESET = 8'h00;

   // reverse_channel_config fields
   localparam int FAST_RETURN_BIT = 7;
   localparam int ROBUST_RETURN_BIT = 6;

   // control register fields
   localparam int SLEEP_BIT = 0;
   localparam int CFG_LINK_EN_BIT = 1;
   localparam int SERIAL_LINK_EN_BIT = 2;
   localparam int REMOTE_WAKE_DIS_BIT = 3;
   localparam int DATA_RATE_BIT = 4;
   localparam int SPREAD_BIT = 5;

   // status register fields
   localparam int ST_SLEEP_BIT = 0;
   localparam int ST_REV_BLACKOUT_BIT = 1;
   localparam int ST_CTRL_READY_BIT = 2;
   localparam int ST_CFG_LINK_BIT = 3;
   localparam int ST_WAKING_BIT = 4;

   // blackout times and derived cycle counts (least times, rounded up)
   localparam int REV_LOCAL_US = 500;
   localparam int REV_PEER_US = 1920;
   localparam int PEER_UP_MS = 2;
   localparam int REV_LOCAL_CYC_DEF = (REV_LOCAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REV_PEER_CYC_DEF = (REV_PEER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PEER_UP_CYC_DEF = (PEER_UP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 18;

   // three-level strap reading, gray along low-mid-high
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_MID = 2'h1,
      LVL_HIGH = 2'h3
   } smc_lvl_type;

   // power state
   typedef enum logic [1:0] {
      PWR_RUN = 2'h0,
      PWR_SLEEP = 2'h1,
      PWR_WAKE = 2'h3
   } smc_pwr_type;

   // reverse channel mode
   typedef enum logic [1:0] {
      REV_LEGACY = 2'h0,
      REV_ROBUST = 2'h1,
      REV_FAST = 2'h3
   } smc_rev_type;

endpackage : smc_pkg

/* File: rtl/smc_timer_if.sv */
/*
 * Carrier between the control logic and a blackout timer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface smc_timer_if;
   logic load;
   logic [smc_pkg::TMR_W-1:0] count;
   logic busy;
   modport ctl (output load, output count, input busy);
   modport tmr (input load, input count, output busy);
endinterface : smc_timer_if

/* File: rtl/smc_blackout_timer.sv */
/*
 * Down-counting blackout timer; busy while the count is not zero.
 * Assumes load is a one-cycle request; a longer pending count is kept.
 */
`timescale 1ns/1ps
module smc_blackout_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control side
   smc_timer_if.tmr tif
);

   logic [smc_pkg::TMR_W-1:0] cnt_ff;

   // a new load never shortens a blackout already running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (tif.load && tif.count > cnt_ff) begin
         cnt_ff <= tif.count;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign tif.busy = (cnt_ff != '0);

endmodule : smc_blackout_timer

/* File: rtl/smc_strap_decode.sv */
/*
 * Resolves the strap pins into three levels and applies the strap tables.
 * Assumes each pin is sensed by two comparators: above the upper and above the lower threshold.
 */
`timescale 1ns/1ps
module smc_strap_decode (
   // sensed pins
   input wire logic [3:0] pins_hi,
   input wire logic [3:0] pins_lo,
   input wire logic robust_hi,
   input wire logic robust_lo,
   input wire logic bw_hi,
   input wire logic bw_lo,
   // decoded values
   output logic [2:0] low_dec,
   output logic [2:0] high_dec,
   output logic robust,
   output logic [1:0] bw_lvl
);

   function automatic smc_pkg::smc_lvl_type level(input logic hi, input logic lo);
      if (hi) begin
         return smc_pkg::LVL_HIGH;
      end else if (lo) begin
         return smc_pkg::LVL_MID;
      end
      return smc_pkg::LVL_LOW;
   endfunction : level

   // result is {mode, first-pin option, second-pin option}; both pairs share the table shape
   function automatic logic [2:0] pair_decode(input smc_pkg::smc_lvl_type a, input smc_pkg::smc_lvl_type b);
      if (a != smc_pkg::LVL_MID && b != smc_pkg::LVL_MID) begin
         return {1'b0, a == smc_pkg::LVL_HIGH, b == smc_pkg::LVL_HIGH};
      end else if (a == smc_pkg::LVL_MID && b != smc_pkg::LVL_HIGH) begin
         return 3'h4;
      end else if (a == smc_pkg::LVL_LOW) begin
         return 3'h5;
      end else if (a == smc_pkg::LVL_HIGH) begin
         return 3'h6;
      end
      return 3'h7;
   endfunction : pair_decode

   assign low_dec = pair_decode(level(pins_hi[1], pins_lo[1]), level(pins_hi[0], pins_lo[0]));
   assign high_dec = pair_decode(level(pins_hi[3], pins_lo[3]), level(pins_hi[2], pins_lo[2]));
   assign robust = (level(robust_hi, robust_lo) != smc_pkg::LVL_LOW);
   assign bw_lvl = level(bw_hi, bw_lo);

endmodule : smc_strap_decode

/* File: rtl/smc_mode_power_ctrl.sv */
/*
 * Mode and power control of a serial video serializer: strap capture, reverse channel
 * mode selection with blackout, sleep and wake sequencing, configuration link control.
 * Assumes register accesses arrive on a simple strobe port fed by the control channel,
 * and that RST_N is the active-low power-down pin.
 */
`timescale 1ns/1ps
module smc_mode_power_ctrl #(
   parameter int REV_LOCAL_CYC = smc_pkg::REV_LOCAL_CYC_DEF,
   parameter int REV_PEER_CYC = smc_pkg::REV_PEER_CYC_DEF,
   parameter int PEER_UP_CYC = smc_pkg::PEER_UP_CYC_DEF
) (
   // clock and power-down reset
   input wire logic CLK,
   input wire logic RST_N,
   // strap sensing
   input wire logic [3:0] STRAP_PINS_HI,
   input wire logic [3:0] STRAP_PINS_LO,
   input wire logic OUTPUT_PIN_ROBUST_STRAP_HI,
   input wire logic OUTPUT_PIN_ROBUST_STRAP_LO,
   input wire logic BUS_WIDTH_PIN_HI,
   input wire logic BUS_WIDTH_PIN_LO,
   // register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_REMOTE,
   output logic [7:0] REG_RDATA,
   // link events
   input wire logic PARALLEL_CLOCK_IN_OK,
   input wire logic LINK_LOCKED,
   input wire logic CAMERA_DISPLAY_SELECT,
   input wire logic CTRL_CMD,
   input wire logic CTRL_CMD_REMOTE,
   input wire logic PEER_MODE_CHANGE,
   input wire logic PEER_POWERUP,
   input wire logic REV_RX_VALID,
   input wire logic REV_RX_BIT,
   // strap results
   output logic CTRL_PROTO_SELECT,
   output logic SPREAD_ENABLE_BIT,
   output logic DATA_RATE_PICK,
   output logic CABLE_TYPE_SELECT,
   output logic AUTO_LINK_DISABLE,
   output logic LATCH_EDGE_SELECT,
   output logic [1:0] BUS_WIDTH_PIN_LVL,
   // reverse channel
   output logic [1:0] REV_MODE,
   output logic REV_BLACKOUT,
   output logic REV_RX_VALID_OUT,
   output logic REV_RX_BIT_OUT,
   // power and link
   output logic SLEEPING,
   output logic PROT_CLEAR,
   output logic SER_OUT_EN,
   output logic OSC_ENABLE,
   output logic CFG_LINK_ACTIVE,
   output logic VIDEO_LOCK_TRY,
   output logic CTRL_CHAN_READY
);

   logic [2:0] low_dec, high_dec, low_ff, high_ff;
   logic [1:0] bw_lvl, bw_ff, rev_mode_ff;
   logic [7:0] rev_cfg_ff, ctrl_cfg_ff, rdata_ff, status;
   smc_pkg::smc_pwr_type pwr_ff, nxt_pwr;
   logic strap_robust, latched_ff, prot_clear_ff, rx_valid_ff, rx_bit_ff;
   logic cfg_active_ff, video_try_ff, ser_en_ff, ready_ff;
   logic wr_rev, wr_ctrl, local_mode_change, wake_cmd, cfg_active, video_try;

   default clocking smc_cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   smc_timer_if rev_tif ();
   smc_timer_if peer_tif ();

   smc_strap_decode u_strap (
      .pins_hi(STRAP_PINS_HI),
      .pins_lo(STRAP_PINS_LO),
      .robust_hi(OUTPUT_PIN_ROBUST_STRAP_HI),
      .robust_lo(OUTPUT_PIN_ROBUST_STRAP_LO),
      .bw_hi(BUS_WIDTH_PIN_HI),
      .bw_lo(BUS_WIDTH_PIN_LO),
      .low_dec(low_dec),
      .high_dec(high_dec),
      .robust(strap_robust),
      .bw_lvl(bw_lvl)
   );

   smc_blackout_timer u_rev_tmr (
      .clk(CLK),
      .rst_n(RST_N),
      .tif(rev_tif.tmr)
   );

   smc_blackout_timer u_peer_tmr (
      .clk(CLK),
      .rst_n(RST_N),
      .tif(peer_tif.tmr)
   );

   // writes are refused until the straps are captured so they cannot race the capture
   assign wr_rev = REG_WR && latched_ff && REG_ADDR == smc_pkg::REV_CFG_ADDR;
   assign wr_ctrl = REG_WR && latched_ff && REG_ADDR == smc_pkg::CTRL_CFG_ADDR;
   assign local_mode_change = wr_rev
      && (REG_WDATA[smc_pkg::ROBUST_RETURN_BIT] != rev_cfg_ff[smc_pkg::ROBUST_RETURN_BIT]
      || REG_WDATA[smc_pkg::FAST_RETURN_BIT] != rev_cfg_ff[smc_pkg::FAST_RETURN_BIT]);

   // strap capture on the first edge after power-down release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         latched_ff <= 1'b0;
         low_ff <= 3'h0;
         high_ff <= 3'h0;
         bw_ff <= 2'h0;
      end else if (!latched_ff) begin
         latched_ff <= 1'b1;
         low_ff <= low_dec;
         high_ff <= high_dec;
         bw_ff <= bw_lvl;
      end
   end

   // reverse channel configuration; strap seeds the robust bit
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rev_cfg_ff <= smc_pkg::REV_CFG_RESET;
      end else if (!latched_ff) begin
         rev_cfg_ff[smc_pkg::ROBUST_RETURN_BIT] <= strap_robust;
      end else if (wr_rev) begin
         rev_cfg_ff <= REG_WDATA;
      end
   end

   // control register; data rate and spread start from the straps
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_cfg_ff <= smc_pkg::CTRL_CFG_RESET;
      end else if (!latched_ff) begin
         ctrl_cfg_ff[smc_pkg::DATA_RATE_BIT] <= low_dec[0];
         ctrl_cfg_ff[smc_pkg::SPREAD_BIT] <= low_dec[1];
      end else if (wr_ctrl) begin
         ctrl_cfg_ff <= REG_WDATA;
      end
   end

   // any command wakes a sleeper; remote ones only while the wake receiver is usable
   assign wake_cmd = (CTRL_CMD && !CTRL_CMD_REMOTE) || (REG_WR && !REG_REMOTE)
      || (((CTRL_CMD && CTRL_CMD_REMOTE) || (REG_WR && REG_REMOTE))
      && !ctrl_cfg_ff[smc_pkg::REMOTE_WAKE_DIS_BIT] && !high_ff[2]);

   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         smc_pkg::PWR_RUN: begin
            if (wr_ctrl && REG_WDATA[smc_pkg::SLEEP_BIT]) begin
               nxt_pwr = smc_pkg::PWR_SLEEP;
            end
         end
         smc_pkg::PWR_SLEEP: begin
            if (wake_cmd) begin
               nxt_pwr = smc_pkg::PWR_WAKE;
            end
         end
         smc_pkg::PWR_WAKE: begin
            if (wr_ctrl) begin
               nxt_pwr = REG_WDATA[smc_pkg::SLEEP_BIT] ? smc_pkg::PWR_SLEEP : smc_pkg::PWR_RUN;
            end
         end
         default: begin
            nxt_pwr = smc_pkg::PWR_RUN;
         end
      endcase
   end

   // power-up always lands in run; the strap for camera use cannot force sleep here
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pwr_ff <= smc_pkg::PWR_RUN;
         prot_clear_ff <= 1'b0;
      end else begin
         pwr_ff <= nxt_pwr;
         prot_clear_ff <= nxt_pwr == smc_pkg::PWR_SLEEP && pwr_ff != smc_pkg::PWR_SLEEP;
      end
   end

   // blackout timers
   assign rev_tif.load = local_mode_change || PEER_MODE_CHANGE;
   assign rev_tif.count = PEER_MODE_CHANGE ? smc_pkg::TMR_W'(REV_PEER_CYC) : smc_pkg::TMR_W'(REV_LOCAL_CYC);
   assign peer_tif.load = PEER_POWERUP;
   assign peer_tif.count = smc_pkg::TMR_W'(PEER_UP_CYC);

   // reverse mode and gated receive path
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rev_mode_ff <= smc_pkg::REV_LEGACY;
         rx_valid_ff <= 1'b0;
         rx_bit_ff <= 1'b0;
      end else begin
         if (!rev_cfg_ff[smc_pkg::ROBUST_RETURN_BIT]) begin
            rev_mode_ff <= smc_pkg::REV_LEGACY;
         end else if (rev_cfg_ff[smc_pkg::FAST_RETURN_BIT]) begin
            rev_mode_ff <= smc_pkg::REV_FAST;
         end else begin
            rev_mode_ff <= smc_pkg::REV_ROBUST;
         end
         rx_valid_ff <= REV_RX_VALID && !rev_tif.busy;
         rx_bit_ff <= REV_RX_BIT;
      end
   end

   // link control: configuration link only while video is not enabled and no clock
   assign video_try = latched_ff && pwr_ff != smc_pkg::PWR_SLEEP
      && (ctrl_cfg_ff[smc_pkg::SERIAL_LINK_EN_BIT] || (!high_ff[1] && PARALLEL_CLOCK_IN_OK));
   assign cfg_active = latched_ff && pwr_ff != smc_pkg::PWR_SLEEP && ctrl_cfg_ff[smc_pkg::CFG_LINK_EN_BIT]
      && !ctrl_cfg_ff[smc_pkg::SERIAL_LINK_EN_BIT] && !PARALLEL_CLOCK_IN_OK;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_active_ff <= 1'b0;
         video_try_ff <= 1'b0;
         ser_en_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         cfg_active_ff <= cfg_active;
         video_try_ff <= video_try;
         ser_en_ff <= video_try || cfg_active;
         ready_ff <= LINK_LOCKED && (video_try_ff || cfg_active_ff) && !peer_tif.busy;
      end
   end

   assign status = {3'h0, pwr_ff == smc_pkg::PWR_WAKE, cfg_active_ff, ready_ff, rev_tif.busy,
      pwr_ff != smc_pkg::PWR_RUN};

   // reads answer one edge later; unmapped addresses read zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            smc_pkg::REV_CFG_ADDR: rdata_ff <= rev_cfg_ff;
            smc_pkg::CTRL_CFG_ADDR: rdata_ff <= ctrl_cfg_ff;
            smc_pkg::STATUS_ADDR: rdata_ff <= status;
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   assign REG_RDATA = rdata_ff;
   assign CTRL_PROTO_SELECT = low_ff[2];
   assign SPREAD_ENABLE_BIT = ctrl_cfg_ff[smc_pkg::SPREAD_BIT];
   assign DATA_RATE_PICK = ctrl_cfg_ff[smc_pkg::DATA_RATE_BIT];
   assign CABLE_TYPE_SELECT = high_ff[2];
   assign AUTO_LINK_DISABLE = high_ff[1];
   assign LATCH_EDGE_SELECT = high_ff[0];
   assign BUS_WIDTH_PIN_LVL = bw_ff;
   assign REV_MODE = rev_mode_ff;
   assign REV_BLACKOUT = rev_tif.busy;
   assign REV_RX_VALID_OUT = rx_valid_ff;
   assign REV_RX_BIT_OUT = rx_bit_ff;
   assign SLEEPING = pwr_ff == smc_pkg::PWR_SLEEP;
   assign PROT_CLEAR = prot_clear_ff;
   assign SER_OUT_EN = ser_en_ff;
   assign OSC_ENABLE = cfg_active_ff;
   assign CFG_LINK_ACTIVE = cfg_active_ff;
   assign VIDEO_LOCK_TRY = video_try_ff;
   assign CTRL_CHAN_READY = ready_ff;

   property p_sleep_now;
      (wr_ctrl && REG_WDATA[smc_pkg::SLEEP_BIT] && pwr_ff == smc_pkg::PWR_RUN) |=> SLEEPING;
   endproperty
   a_sleep_now: assert property (p_sleep_now) else $error("sleep write did not sleep");
   property p_prot_clear;
      $rose(SLEEPING) |-> PROT_CLEAR && $stable(rev_cfg_ff);
   endproperty
   a_prot_clear: assert property (p_prot_clear) else $error("sleep entry clear wrong");
   property p_rev_blackout;
      local_mode_change |=> REV_BLACKOUT [*8];
   endproperty
   a_rev_blackout: assert property (p_rev_blackout) else $error("no blackout after mode change");
   property p_rx_gate;
      REV_BLACKOUT |=> !REV_RX_VALID_OUT;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("traffic passed in blackout");
   property p_remote_wake;
      (SLEEPING && !(CTRL_CMD && !CTRL_CMD_REMOTE) && !(REG_WR && !REG_REMOTE)
         && (ctrl_cfg_ff[smc_pkg::REMOTE_WAKE_DIS_BIT] || CABLE_TYPE_SELECT)) |=> SLEEPING;
   endproperty
   a_remote_wake: assert property (p_remote_wake) else $error("woke remotely with remote wake off");
   property p_rev_mode;
      rev_cfg_ff[smc_pkg::ROBUST_RETURN_BIT] && rev_cfg_ff[smc_pkg::FAST_RETURN_BIT] |=> REV_MODE == smc_pkg::REV_FAST;
   endproperty
   a_rev_mode: assert property (p_rev_mode) else $error("fast mode not selected");
   property p_strap;
      !latched_ff |=> CABLE_TYPE_SELECT == $past(high_dec[2]) && SPREAD_ENABLE_BIT == $past(low_dec[1]);
   endproperty
   a_strap: assert property (p_strap) else $error("straps not captured");
   property p_cfg_link;
      ctrl_cfg_ff[smc_pkg::SERIAL_LINK_EN_BIT] |=> !CFG_LINK_ACTIVE;
   endproperty
   a_cfg_link: assert property (p_cfg_link) else $error("config link beside video link");
   property p_peer_up;
      PEER_POWERUP |=> ##1 !CTRL_CHAN_READY [*4];
   endproperty
   a_peer_up: assert property (p_peer_up) else $error("control channel ready during peer start");

endmodule : smc_mode_power_ctrl

/* File: sim/smc_peer_model.sv */
/*
 * Far-side deserializer model: mode change and power-up notices, link lock, reverse bits.
 * Assumes the bench requests each event one clock ahead, on the same clock.
 */
`timescale 1ns/1ps
module smc_peer_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // requests from the bench
   input wire logic chg_req,
   input wire logic pup_req,
   input wire logic lock_req,
   input wire logic tx_en,
   input wire logic tx_bit,
   // toward the serializer
   output logic mode_chg,
   output logic powerup,
   output logic locked,
   output logic rx_valid,
   output logic rx_bit
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_chg <= 1'b0;
         powerup <= 1'b0;
         locked <= 1'b0;
         rx_valid <= 1'b0;
         rx_bit <= 1'b0;
      end else begin
         mode_chg <= chg_req;
         powerup <= pup_req;
         locked <= lock_req;
         rx_valid <= tx_en;
         // an idle line toggles so a stale bit never passes for data
         rx_bit <= tx_en ? tx_bit : ~rx_bit;
      end
   end
endmodule : smc_peer_model

/* File: sim/tb.sv */
/*
 * Self-checking bench of the mode and power control block with a far-side model.
 * Assumes short blackout counts so the run stays brief.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
   localparam int LOC = 20;
   localparam int PEER = 40;
   localparam int PUP = 30;
   localparam logic [7:0] A_REV = smc_pkg::REV_CFG_ADDR;
   localparam logic [7:0] A_CTL = smc_pkg::CTRL_CFG_ADDR;
   localparam logic [7:0] A_ST = smc_pkg::STATUS_ADDR;
   logic clk = 0, rst_n = 0, rb_hi = 0, rb_lo = 0, bw_hi = 0, bw_lo = 0;
   logic [3:0] sp_hi = '0, sp_lo = '0;
   logic wr = 0, rd = 0, remote = 0, clk_ok = 0, camera_display_select = 0, cmd = 0, cmd_rem = 0;
   logic [7:0] addr = '0, wdata = '0, rdata, rd8;
   logic chg_req = 0, pup_req = 0, lock_req = 0, tx_en = 0, tx_bit = 0;
   logic peer_chg, peer_pup, locked, rx_v, rx_b, proto, spread, data_rate_pick, cable, auto_link_disable, edg;
   logic rv_out, rb_out, sleeping, pclr, ser_en, osc, cfg, vtry, ready, blk;
   logic [1:0] bw_lvl, rmode;
   logic [2:0] exp3;
   // fast mode is only written while the straps give rate pick 0; trim is left to the user
   logic [7:0] rv[4] = '{8'h40, 8'hC0, 8'h00, 8'h80};
   logic [1:0] rm[4] = '{2'h1, 2'h3, 2'h0, 2'h0};
   int fs[9] = '{0, 0, 2, 2, 1, 1, 0, 2, 1};
   int ss[9] = '{0, 2, 0, 2, 0, 1, 1, 1, 2};
   int n_mismatch = 0, num_checks = 0;
   int unsigned seed = 80564;

   always #5 clk = ~clk;

   smc_peer_model peer_u (.clk(clk), .rst_n(rst_n), .chg_req(chg_req), .pup_req(pup_req), .lock_req(lock_req),
      .tx_en(tx_en), .tx_bit(tx_bit), .mode_chg(peer_chg), .powerup(peer_pup), .locked(locked),
      .rx_valid(rx_v), .rx_bit(rx_b));

   smc_mode_power_ctrl #(.REV_LOCAL_CYC(LOC), .REV_PEER_CYC(PEER), .PEER_UP_CYC(PUP)) dut_u (
      .CLK(clk), .RST_N(rst_n), .STRAP_PINS_HI(sp_hi), .STRAP_PINS_LO(sp_lo),
      .OUTPUT_PIN_ROBUST_STRAP_HI(rb_hi), .OUTPUT_PIN_ROBUST_STRAP_LO(rb_lo),
      .BUS_WIDTH_PIN_HI(bw_hi), .BUS_WIDTH_PIN_LO(bw_lo), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_REMOTE(remote), .REG_RDATA(rdata), .PARALLEL_CLOCK_IN_OK(clk_ok),
      .LINK_LOCKED(locked), .CAMERA_DISPLAY_SELECT(camera_display_select), .CTRL_CMD(cmd), .CTRL_CMD_REMOTE(cmd_rem),
      .PEER_MODE_CHANGE(peer_chg), .PEER_POWERUP(peer_pup), .REV_RX_VALID(rx_v), .REV_RX_BIT(rx_b),
      .CTRL_PROTO_SELECT(proto), .SPREAD_ENABLE_BIT(spread), .DATA_RATE_PICK(data_rate_pick), .CABLE_TYPE_SELECT(cable),
      .AUTO_LINK_DISABLE(auto_link_disable), .LATCH_EDGE_SELECT(edg), .BUS_WIDTH_PIN_LVL(bw_lvl), .REV_MODE(rmode),
      .REV_BLACKOUT(blk), .REV_RX_VALID_OUT(rv_out), .REV_RX_BIT_OUT(rb_out), .SLEEPING(sleeping),
      .PROT_CLEAR(pclr), .SER_OUT_EN(ser_en), .OSC_ENABLE(osc), .CFG_LINK_ACTIVE(cfg),
      .VIDEO_LOCK_TRY(vtry), .CTRL_CHAN_READY(ready));

   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // levels 0 low, 1 mid, 2 high; result is {mid seen, first field, second field}
   function automatic logic [2:0] dec(int f, int s);
      logic m;
      m = (f == 1) || (s == 1);
      return {m, f == 2 || (f == 1 && s == 2), s == 2 || (m && f == 0)};
   endfunction : dec

   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wreg

   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rd8 = rdata;
   endtask : rreg

   // 0 peer mode change, 1 control command, 2 peer power-up
   task automatic pulse(int w);
      @(posedge clk);
      if (w == 0) chg_req <= 1'b1;
      else if (w == 1) cmd <= 1'b1;
      else pup_req <= 1'b1;
      @(posedge clk);
      {chg_req, cmd, pup_req} <= 3'h0;
      #1;
   endtask : pulse

   task automatic boot(int f, int s, int r);
      @(posedge clk);
      rst_n <= 1'b0;
      sp_hi <= {f == 2, s == 2, f == 2, s == 2};
      sp_lo <= {f > 0, s > 0, f > 0, s > 0};
      rb_hi <= r == 2;
      rb_lo <= r > 0;
      bw_hi <= r == 2;
      bw_lo <= r > 0;
      tick(8);
      `CHK("ser_en_off", 1'b0, ser_en)
      @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
   endtask : boot

   task automatic blk_len(int exp_n);
      int n;
      n = 0;
      repeat (3) if (blk !== 1'b1) tick();
      while (blk === 1'b1 && n < 500) begin
         if (n == 5) `CHK("rx_gated", 1'b0, rv_out)
         n++;
         tick();
      end
      `CHK("blackout_len", exp_n, n)
   endtask : blk_len

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end

   initial begin
      for (int i = 0; i < 9; i++) begin
         boot(fs[i], ss[i], i % 3);
         exp3 = dec(fs[i], ss[i]);
         `CHK("low_pair", exp3, {proto, spread, data_rate_pick})
         `CHK("high_pair", exp3, {cable, auto_link_disable, edg})
         `CHK("bw_lvl", (i % 3 == 2) ? 2'h3 : 2'(i % 3), bw_lvl)
         rreg(A_REV);
         `CHK("robust_seed", i % 3 != 0, rd8[6])
      end
      wreg(A_CTL, 8'h00);
      `CHK("rate_spread_ovr", 2'h0, {spread, data_rate_pick})
      $display("strap test done");
      boot(0, 0, 0);
      rreg(8'h33);
      `CHK("unmapped", 8'h00, rd8)
      @(posedge clk);
      tx_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         tx_bit <= 1'(xs());
         wreg(A_REV, rv[i]);
         blk_len(LOC);
         tick(2);
         `CHK("rx_resume", {1'b1, tx_bit}, {rv_out, rb_out})
         `CHK("rev_mode", rm[i], rmode)
      end
      pulse(0);
      blk_len(PEER);
      $display("reverse test done");
      wreg(A_CTL, 8'h08);
      wreg(A_CTL, 8'h09);
      `CHK("sleep_now", 2'h3, {sleeping, pclr})
      rreg(A_REV);
      `CHK("cfg_kept", 8'h80, rd8)
      cmd_rem <= 1'b1;
      pulse(1);
      tick(2);
      `CHK("no_remote_wake", 1'b1, sleeping)
      cmd_rem <= 1'b0;
      pulse(1);
      tick(2);
      rreg(A_ST);
      `CHK("waking", 2'h1, {sleeping, rd8[4]})
      wreg(A_CTL, 8'h08);
      rreg(A_ST);
      `CHK("run", 2'h0, {rd8[4], rd8[0]})
      wreg(A_CTL, 8'h01);
      cmd_rem <= 1'b1;
      pulse(1);
      tick(2);
      `CHK("remote_wake", 1'b0, sleeping)
      cmd_rem <= 1'b0;
      wreg(A_CTL, 8'h00);
      $display("sleep test done");
      lock_req <= 1'b1;
      wreg(A_CTL, 8'h02);
      tick(4);
      `CHK("cfg_link", 3'h7, {cfg, osc, ready})
      pulse(2);
      tick(6);
      `CHK("peer_up_block", 1'b0, ready)
      tick(PUP + 5);
      `CHK("peer_up_end", 1'b1, ready)
      wreg(A_CTL, 8'h06);
      tick(2);
      `CHK("video_over_cfg", 3'h3, {cfg, vtry, ser_en})
      boot(0, 0, 0);
      rreg(A_CTL);
      `CHK("ctl_reset", 8'h00, rd8)
      $display("link test done");
      close_out();
   end
endmodule : tb
